// ---- core/aerr_pkg.sv ----
// Package: offsets, field layouts, reset values and carriers of the error reporting registers
package aerr_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] AERR_OFF_UNC_STATUS = 12'h104;
    localparam logic [11:0] AERR_OFF_UNC_SEV    = 12'h10c;
    localparam logic [11:0] AERR_OFF_COR_STATUS = 12'h110;
    localparam logic [11:0] AERR_OFF_COR_MASK   = 12'h114;
    localparam logic [11:0] AERR_OFF_CAP_CTRL   = 12'h118;
    localparam logic [11:0] AERR_OFF_HDR_LOG0   = 12'h11c;
    localparam logic [11:0] AERR_OFF_HDR_LOG1   = 12'h120;
    localparam logic [11:0] AERR_OFF_HDR_LOG2   = 12'h124;
    localparam logic [11:0] AERR_OFF_HDR_LOG3   = 12'h128;

    // ------------------------------------------------------------------
    // Implemented bits and reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] AERR_UNC_IMPL      = 32'h003f_f011;
    localparam logic [31:0] AERR_UNC_SEV_RST   = 32'h0006_2011;
    localparam logic [31:0] AERR_COR_IMPL      = 32'h0000_31c1;
    localparam logic [31:0] AERR_COR_MASK_RST  = 32'h0000_2000;
    localparam logic [31:0] AERR_ZERO_WORD     = 32'h0000_0000;
    localparam logic [4:0]  AERR_FEP_RST       = 5'h00;
    localparam logic [127:0] AERR_HDR_RST      = 128'h0;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int AERR_UNC_ECRC_BIT   = 19;
    localparam int AERR_CAP_FEP_LSB    = 0;
    localparam int AERR_CAP_FEP_MSB    = 4;
    localparam int AERR_CAP_GEN_CAP    = 5;
    localparam int AERR_CAP_GEN_EN     = 6;
    localparam int AERR_CAP_CHK_CAP    = 7;
    localparam int AERR_CAP_CHK_EN     = 8;
    localparam int AERR_HDR_DW         = 4;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        AERR_SEV_COR,
        AERR_SEV_NONFATAL,
        AERR_SEV_FATAL
    } aerr_sev_t;

    typedef struct packed {
        logic        valid;
        aerr_sev_t   sev;
    } aerr_msg_t;

    typedef struct packed {
        logic [31:0]  unc;
        logic [31:0]  cor;
        logic [127:0] hdr;
    } aerr_evt_t;

endpackage

// ---- core/aerr_pick.sv ----
// Lowest set bit finder used for first error selection
`timescale 1ns/100ps
module aerr_pick #(
    parameter int WIDTH = 32
) (
    input  wire logic [WIDTH-1:0]         vec,
    output logic                          any,
    output logic [$clog2(WIDTH)-1:0]      idx
);
    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (WIDTH < 2) begin : g_chk
        $error("aerr_pick needs WIDTH of 2 or more");
    end

    // Lowest index wins, so ties in one cycle resolve deterministically
    function automatic logic [$clog2(WIDTH)-1:0] lowest(input logic [WIDTH-1:0] v);
        logic [$clog2(WIDTH)-1:0] r;
        r = '0;
        for (int i = WIDTH - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = i[$clog2(WIDTH)-1:0];
            end
        end
        return r;
    endfunction

    assign any = |vec;
    assign idx = lowest(vec);
endmodule // aerr_pick

// ---- core/aerr_regs.sv ----
// Error reporting register bank with header log and first error pointer
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
module aerr_regs #(
    parameter int ADDR_W = 12
) (
    input  wire logic                 SYS_CLK,
    input  wire logic                 SYS_RST,
    input  wire logic                 PORT_RST,
    input  wire logic [ADDR_W-1:0]    REG_ADDR,
    input  wire logic [31:0]          REG_WDATA,
    input  wire logic                 REG_WR,
    input  wire logic                 REG_RD,
    output logic [31:0]               REG_RDATA,
    input  wire aerr_pkg::aerr_evt_t  ERR_EVT,
    output aerr_pkg::aerr_msg_t       ERR_MSG,
    output logic                      ECRC_GEN_EN,
    output logic                      ECRC_CHK_EN
);
    import aerr_pkg::*;

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (ADDR_W != 12) begin : g_chk
        $error("aerr_regs decodes a 12-bit configuration address");
    end

    // ------------------------------------------------------------------
    // Sticky state
    // ------------------------------------------------------------------
    logic [31:0]  unc_status_r;
    logic [31:0]  unc_status_nxt;
    logic [31:0]  unc_sev_r;
    logic [31:0]  unc_sev_nxt;
    logic [31:0]  cor_status_r;
    logic [31:0]  cor_status_nxt;
    logic [31:0]  cor_mask_r;
    logic [31:0]  cor_mask_nxt;
    logic [4:0]   fep_r;
    logic [4:0]   fep_nxt;
    logic         gen_en_r;
    logic         gen_en_nxt;
    logic         chk_en_r;
    logic         chk_en_nxt;
    logic [31:0]  hdr_log_r [AERR_HDR_DW];
    logic         log_held_r;
    logic         log_held_nxt;
    logic         log_src_unc_r;
    logic         log_src_unc_nxt;
    logic [4:0]   log_src_idx_r;
    logic [4:0]   log_src_idx_nxt;

    // Non-sticky outputs
    logic [31:0]  rdata_r;
    logic [31:0]  rdata_nxt;
    aerr_msg_t    msg_r;
    aerr_msg_t    msg_nxt;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    wire logic hit_unc_status = (REG_ADDR == AERR_OFF_UNC_STATUS);
    wire logic hit_unc_sev    = (REG_ADDR == AERR_OFF_UNC_SEV);
    wire logic hit_cor_status = (REG_ADDR == AERR_OFF_COR_STATUS);
    wire logic hit_cor_mask   = (REG_ADDR == AERR_OFF_COR_MASK);
    wire logic hit_cap_ctrl   = (REG_ADDR == AERR_OFF_CAP_CTRL);
    wire logic hit_hdr0       = (REG_ADDR == AERR_OFF_HDR_LOG0);
    wire logic hit_hdr1       = (REG_ADDR == AERR_OFF_HDR_LOG1);
    wire logic hit_hdr2       = (REG_ADDR == AERR_OFF_HDR_LOG2);
    wire logic hit_hdr3       = (REG_ADDR == AERR_OFF_HDR_LOG3);

    // Write strobes per register
    wire logic wr_unc_status  = REG_WR & hit_unc_status;
    wire logic wr_unc_sev     = REG_WR & hit_unc_sev;
    wire logic wr_cor_status  = REG_WR & hit_cor_status;
    wire logic wr_cor_mask    = REG_WR & hit_cor_mask;
    wire logic wr_cap_ctrl    = REG_WR & hit_cap_ctrl;

    // ------------------------------------------------------------------
    // Incoming events
    // ------------------------------------------------------------------
    // ECRC errors only count while checking is switched on
    wire logic [31:0] ecrc_gate = chk_en_r ? 32'hffff_ffff :
                                  ~(32'h0000_0001 << AERR_UNC_ECRC_BIT);
    wire logic [31:0] unc_evt   = ERR_EVT.unc & AERR_UNC_IMPL & ecrc_gate;
    wire logic [31:0] cor_evt   = ERR_EVT.cor & AERR_COR_IMPL;
    // Unmasked correctable events are the ones that log and message
    wire logic [31:0] cor_live  = cor_evt & ~cor_mask_r;

    // ------------------------------------------------------------------
    // First error selection
    // ------------------------------------------------------------------
    logic        unc_any;
    logic [4:0]  unc_idx;
    logic        cor_any;
    logic [4:0]  cor_idx;

    aerr_pick #(
        .WIDTH (32)
    ) u_pick_unc (
        .vec   (unc_evt),
        .any   (unc_any),
        .idx   (unc_idx)
    );

    aerr_pick #(
        .WIDTH (32)
    ) u_pick_cor (
        .vec   (cor_live),
        .any   (cor_any),
        .idx   (cor_idx)
    );

    // ------------------------------------------------------------------
    // Status registers: event set wins over a write of one
    // ------------------------------------------------------------------
    wire logic [31:0] unc_clr = wr_unc_status ? REG_WDATA : AERR_ZERO_WORD;
    wire logic [31:0] cor_clr = wr_cor_status ? REG_WDATA : AERR_ZERO_WORD;

    // Bits 0,4,12..21 set by hardware, cleared by writing one
    assign unc_status_nxt = ((unc_status_r & ~unc_clr) | unc_evt) & AERR_UNC_IMPL;
    // Bits 0,6,7,8,12,13: receiver, bad packets, replay, advisory
    assign cor_status_nxt = ((cor_status_r & ~cor_clr) | cor_evt)
                            & AERR_COR_IMPL;
    // Timer timeout and advisory nonfatal bits share this path

    // ------------------------------------------------------------------
    // Read-write sticky registers; reserved bits never store
    // ------------------------------------------------------------------
    assign unc_sev_nxt  = wr_unc_sev ? (REG_WDATA & AERR_UNC_IMPL) : unc_sev_r;
    assign cor_mask_nxt = wr_cor_mask ? (REG_WDATA & AERR_COR_IMPL) : cor_mask_r;
    assign gen_en_nxt   = wr_cap_ctrl ? REG_WDATA[AERR_CAP_GEN_EN] : gen_en_r;
    assign chk_en_nxt   = wr_cap_ctrl ? REG_WDATA[AERR_CAP_CHK_EN] : chk_en_r;

    // ------------------------------------------------------------------
    // Header log ownership
    // ------------------------------------------------------------------
    // The log stays owned until software clears the status bit behind it
    wire logic src_still_set = log_src_unc_r ? unc_status_r[log_src_idx_r]
                                             : cor_status_r[log_src_idx_r];
    wire logic log_free      = ~log_held_r | ~src_still_set;
    // Uncorrectable errors take the log ahead of correctable ones
    wire logic cap_unc       = log_free & unc_any;
    wire logic cap_cor       = log_free & ~unc_any & cor_any;
    wire logic capture       = cap_unc | cap_cor;

    assign log_held_nxt    = capture ? 1'b1 : (log_held_r & src_still_set);
    assign log_src_unc_nxt = capture ? cap_unc : log_src_unc_r;
    assign log_src_idx_nxt = cap_unc ? unc_idx : (cap_cor ? cor_idx : log_src_idx_r);
    // Pointer only moves for an uncorrectable first error
    assign fep_nxt         = cap_unc ? unc_idx : fep_r;

    // ------------------------------------------------------------------
    // Error message toward the root complex
    // ------------------------------------------------------------------
    // Highest severity in the cycle wins; one message per cycle at most
    wire logic unc_fatal  = |(unc_evt & unc_sev_r);
    wire logic unc_nonfat = |(unc_evt & ~unc_sev_r);
    wire logic cor_msg    = |cor_live;

    always_comb begin
        msg_nxt.valid = 1'b0;
        msg_nxt.sev   = AERR_SEV_COR;
        if (unc_fatal) begin
            msg_nxt.valid = 1'b1;
            msg_nxt.sev   = AERR_SEV_FATAL;
        end else if (unc_nonfat) begin
            msg_nxt.valid = 1'b1;
            msg_nxt.sev   = AERR_SEV_NONFATAL;
        end else if (cor_msg) begin
            msg_nxt.valid = 1'b1;
            msg_nxt.sev   = AERR_SEV_COR;
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Capability bits are constant ones; reserved bits read zero
    wire logic [31:0] cap_word = {23'h0,
                                  chk_en_r,
                                  1'b1,
                                  gen_en_r,
                                  1'b1,
                                  fep_r};

    // Unmapped addresses answer zero
    always_comb begin
        rdata_nxt = AERR_ZERO_WORD;
        if (REG_RD) begin
            case (1'b1)
                hit_unc_status: rdata_nxt = unc_status_r;
                hit_unc_sev:    rdata_nxt = unc_sev_r;
                hit_cor_status: rdata_nxt = cor_status_r;
                hit_cor_mask:   rdata_nxt = cor_mask_r;
                hit_cap_ctrl:   rdata_nxt = cap_word;
                hit_hdr0:       rdata_nxt = hdr_log_r[0];
                hit_hdr1:       rdata_nxt = hdr_log_r[1];
                hit_hdr2:       rdata_nxt = hdr_log_r[2];
                hit_hdr3:       rdata_nxt = hdr_log_r[3];
                default:        rdata_nxt = AERR_ZERO_WORD;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Sticky flops: only the power-on reset touches them
    // ------------------------------------------------------------------
    // Port reset is deliberately absent here so logs survive link recovery
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            unc_status_r <= AERR_ZERO_WORD;
            unc_sev_r    <= AERR_UNC_SEV_RST;
            cor_status_r <= AERR_ZERO_WORD;
            cor_mask_r   <= AERR_COR_MASK_RST;
            fep_r        <= AERR_FEP_RST;
            gen_en_r     <= 1'b0;
            chk_en_r     <= 1'b0;
        end else begin
            unc_status_r <= unc_status_nxt;
            unc_sev_r    <= unc_sev_nxt;
            cor_status_r <= cor_status_nxt;
            cor_mask_r   <= cor_mask_nxt;
            fep_r        <= fep_nxt;
            gen_en_r     <= gen_en_nxt;
            chk_en_r     <= chk_en_nxt;
        end
    end

    // Log ownership, also sticky
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            log_held_r    <= 1'b0;
            log_src_unc_r <= 1'b0;
            log_src_idx_r <= AERR_FEP_RST;
        end else begin
            log_held_r    <= log_held_nxt;
            log_src_unc_r <= log_src_unc_nxt;
            log_src_idx_r <= log_src_idx_nxt;
        end
    end

    // Header log array; doublewords arrive already in big-endian byte order
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            for (int i = 0; i < AERR_HDR_DW; i++) begin
                hdr_log_r[i] <= AERR_ZERO_WORD;
            end
        end else if (capture) begin
            for (int i = 0; i < AERR_HDR_DW; i++) begin
                hdr_log_r[i] <= ERR_EVT.hdr[32*i +: 32];
            end
        end
    end

    // ------------------------------------------------------------------
    // Non-sticky outputs: cleared by either reset
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rdata_r   <= AERR_ZERO_WORD;
            msg_r     <= '0;
        end else if (PORT_RST) begin
            rdata_r   <= AERR_ZERO_WORD;
            msg_r     <= '0;
        end else begin
            rdata_r   <= rdata_nxt;
            msg_r     <= msg_nxt;
        end
    end

    // Enables leave straight from their flops
    assign REG_RDATA   = rdata_r;
    assign ERR_MSG     = msg_r;
    assign ECRC_GEN_EN = gen_en_r;
    assign ECRC_CHK_EN = chk_en_r;

endmodule // aerr_regs

// ---- verification/aerr_evt_src.sv ----
// Far-side event source model that feeds error events into the register bank
`timescale 1ns/100ps
module aerr_evt_src (
    input  wire logic           SYS_CLK,
    input  wire logic           fire,
    input  wire logic [31:0]    unc,
    input  wire logic [31:0]    cor,
    input  wire logic [127:0]   hdr,
    output aerr_pkg::aerr_evt_t evt
);
    import aerr_pkg::*;

    logic [127:0] last_hdr_r = 128'h0;

    // Header is undefined between events: a toggling copy keeps stale data from matching
    always @(posedge SYS_CLK) begin
        last_hdr_r <= fire ? hdr : ~last_hdr_r;
    end

    // Events are one-cycle pulses; the header qualifies only that cycle
    assign evt = fire ? {unc, cor, hdr} : {AERR_ZERO_WORD, AERR_ZERO_WORD, ~last_hdr_r};
endmodule // aerr_evt_src

// ---- verification/aerr_regs_monitor.sv ----
// Port-level checker of the error reporting register bank
`timescale 1ns/100ps
module aerr_regs_monitor #(
    parameter int ADDR_W = 12
) (
    input wire logic                SYS_CLK,
    input wire logic                SYS_RST,
    input wire logic                PORT_RST,
    input wire logic [ADDR_W-1:0]   REG_ADDR,
    input wire logic [31:0]         REG_WDATA,
    input wire logic                REG_WR,
    input wire logic                REG_RD,
    input wire logic [31:0]         REG_RDATA,
    input wire aerr_pkg::aerr_evt_t ERR_EVT,
    input wire aerr_pkg::aerr_msg_t ERR_MSG,
    input wire logic                ECRC_GEN_EN,
    input wire logic                ECRC_CHK_EN
);
    import aerr_pkg::*;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);

    // ------------------------------------------------------------------
    // Decodes of bus and event traffic
    // ------------------------------------------------------------------
    wire logic cap_wr  = REG_WR && REG_ADDR == AERR_OFF_CAP_CTRL;
    wire logic cap_rd  = REG_RD && !PORT_RST && REG_ADDR == AERR_OFF_CAP_CTRL;
    wire logic cor_rd  = REG_RD && (REG_ADDR == AERR_OFF_COR_STATUS
                         || REG_ADDR == AERR_OFF_COR_MASK);
    wire logic far_rd  = REG_RD && (REG_ADDR < 12'h104 || REG_ADDR > 12'h128
                         || REG_ADDR == 12'h108 || REG_ADDR[1:0] != 2'b00);
    wire logic unc_any = |(ERR_EVT.unc & AERR_UNC_IMPL);
    wire logic unc_hit = |(ERR_EVT.unc & AERR_UNC_IMPL & ~(32'h0000_0001 << AERR_UNC_ECRC_BIT));
    wire logic any_evt = unc_any || |(ERR_EVT.cor & AERR_COR_IMPL);

    property p_rd_idle;
        !$past(REG_RD) |-> REG_RDATA == AERR_ZERO_WORD;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");
    property p_cap_const;
        $past(cap_rd) |-> REG_RDATA[AERR_CAP_GEN_CAP] && REG_RDATA[AERR_CAP_CHK_CAP]
            && REG_RDATA[31:9] == 23'h00_0000;
    endproperty
    a_cap_const: assert property (p_cap_const) else $error("capability bad");
    property p_en_write;
        cap_wr ##1 !cap_wr |=> ECRC_GEN_EN == $past(REG_WDATA[AERR_CAP_GEN_EN], 2)
            && ECRC_CHK_EN == $past(REG_WDATA[AERR_CAP_CHK_EN], 2);
    endproperty
    a_en_write: assert property (p_en_write) else $error("ecrc enable lost");
    property p_en_hold;
        !$past(cap_wr) && !$past(cap_wr, 2) |-> $stable(ECRC_GEN_EN) && $stable(ECRC_CHK_EN);
    endproperty
    a_en_hold: assert property (p_en_hold) else $error("ecrc enable moved alone");
    property p_port_rst;
        PORT_RST |=> !ERR_MSG.valid && REG_RDATA == AERR_ZERO_WORD;
    endproperty
    a_port_rst: assert property (p_port_rst) else $error("port reset not idle");
    property p_unc_msg;
        unc_hit && !PORT_RST |=> ERR_MSG.valid && ERR_MSG.sev != AERR_SEV_COR;
    endproperty
    a_unc_msg: assert property (p_unc_msg) else $error("uncorrectable lost");
    property p_msg_cause;
        ERR_MSG.valid |-> $past(any_evt);
    endproperty
    a_msg_cause: assert property (p_msg_cause) else $error("message without event");
    property p_cor_sev;
        ERR_MSG.valid && !$past(unc_any) |-> ERR_MSG.sev == AERR_SEV_COR;
    endproperty
    a_cor_sev: assert property (p_cor_sev) else $error("correctable severity wrong");
    property p_cor_rsvd;
        $past(cor_rd) |-> (REG_RDATA & ~AERR_COR_IMPL) == AERR_ZERO_WORD;
    endproperty
    a_cor_rsvd: assert property (p_cor_rsvd) else $error("reserved bits set");
    property p_unmapped;
        $past(far_rd) |-> REG_RDATA == AERR_ZERO_WORD;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule // aerr_regs_monitor

bind aerr_regs aerr_regs_monitor #(.ADDR_W(ADDR_W)) u_mon (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
    .PORT_RST(PORT_RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .ERR_EVT(ERR_EVT), .ERR_MSG(ERR_MSG),
    .ECRC_GEN_EN(ECRC_GEN_EN), .ECRC_CHK_EN(ECRC_CHK_EN));

// ---- verification/aerr_regs_tb.sv ----
// Self-checking testbench of the error reporting register bank
`timescale 1ns/100ps
module aerr_regs_tb;
    import aerr_pkg::*;
    logic         clk, rst, port_rst, wr, rd, fire, rd_d, gen, chk;
    logic [11:0]  addr;
    logic [31:0]  wdata, rdata, e_unc, e_cor, sev_v;
    logic [127:0] e_hdr, h, h2;
    aerr_evt_t    evt;
    aerr_msg_t    msg;
    logic [31:0]  exp_rd[$];
    aerr_msg_t    exp_msg[$];
    int           errors = 0;
    int           n_compared = 0;
    int           i;
    int           cor_bits[6] = '{0, 6, 7, 8, 12, 13};

    aerr_evt_src u_src (.SYS_CLK(clk), .fire(fire), .unc(e_unc), .cor(e_cor), .hdr(e_hdr),
                        .evt(evt));
    aerr_regs #(.ADDR_W(12)) uut (.SYS_CLK(clk), .SYS_RST(rst), .PORT_RST(port_rst),
        .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
        .ERR_EVT(evt), .ERR_MSG(msg), .ECRC_GEN_EN(gen), .ECRC_CHK_EN(chk));

    always #2.5 clk = ~clk;

    // ------------------------------------------------------------------
    // Compare tasks and closing report
    // ------------------------------------------------------------------
    task automatic cmp32(input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic cmp_msg(input aerr_msg_t e, input aerr_msg_t g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Bus and event drivers; the read and pulse drivers note their expected results
    // ------------------------------------------------------------------
    task automatic wr32(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd32(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a; rd <= 1'b1; exp_rd.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask
    task automatic pulse(input logic [31:0] u, input logic [31:0] c, input logic [127:0] hh,
                         input logic want, input aerr_sev_t s);
        @(posedge clk);
        fire <= 1'b1; e_unc <= u; e_cor <= c; e_hdr <= hh;
        if (want) exp_msg.push_back('{valid: 1'b1, sev: s});
        @(posedge clk);
        fire <= 1'b0;
    endtask
    // Bounded wait for all notes to be consumed; late strays still get two cycles to show
    task automatic drain(input string name);
        int k;
        k = 0;
        while ((exp_rd.size() != 0 || exp_msg.size() != 0) && k < 20) begin
            @(posedge clk);
            k++;
        end
        if (exp_rd.size() != 0 || exp_msg.size() != 0) begin
            errors++;
            print_verdict();
        end
        repeat (2) @(posedge clk);
        $display("test %s done", name);
    endtask

    // Watcher: read answers one cycle after the strobe, messages whenever they pulse
    always @(posedge clk) begin
        rd_d <= rd;
        if (rd_d && exp_rd.size() != 0) cmp32(exp_rd.pop_front(), rdata);
        if (msg.valid === 1'b1) begin
            if (exp_msg.size() == 0) cmp_msg('{valid: 1'b0, sev: AERR_SEV_COR}, msg);
            else cmp_msg(exp_msg.pop_front(), msg);
        end
    end

    initial begin
        clk = 0; rst = 1; port_rst = 0; wr = 0; rd = 0; fire = 0;
        addr = 12'h000; wdata = 32'h0000_0000; e_unc = 32'h0000_0000; e_cor = 32'h0000_0000;
        e_hdr = 128'h0;
        void'($urandom(64580));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd32(AERR_OFF_UNC_SEV, AERR_UNC_SEV_RST);
        rd32(AERR_OFF_COR_MASK, AERR_COR_MASK_RST);
        rd32(AERR_OFF_COR_STATUS, 32'h0000_0000);
        rd32(AERR_OFF_CAP_CTRL, 32'h0000_00a0);
        rd32(AERR_OFF_UNC_STATUS, 32'h0000_0000);
        rd32(12'h108, 32'h0000_0000);
        drain("reset values");
        // First error owns the log and the pointer until its status is cleared
        h = {$urandom, $urandom, $urandom, $urandom};
        h2 = {$urandom, $urandom, $urandom, $urandom};
        pulse(32'h0000_2000, 32'h0000_0000, h, 1'b1, AERR_SEV_FATAL);
        rd32(AERR_OFF_UNC_STATUS, 32'h0000_2000);
        rd32(AERR_OFF_CAP_CTRL, 32'h0000_00ad);
        for (i = 0; i < AERR_HDR_DW; i++)
            rd32(AERR_OFF_HDR_LOG0 + 12'(4 * i), h[32 * i +: 32]);
        pulse(32'h0000_1000, 32'h0000_0000, h2, 1'b1, AERR_SEV_NONFATAL);
        rd32(AERR_OFF_HDR_LOG0, h[31:0]);
        rd32(AERR_OFF_CAP_CTRL, 32'h0000_00ad);
        wr32(AERR_OFF_UNC_STATUS, 32'h0000_3000);
        rd32(AERR_OFF_UNC_STATUS, 32'h0000_0000);
        pulse(32'h0000_0010, 32'h0000_0000, h2, 1'b1, AERR_SEV_FATAL);
        wr32(AERR_OFF_HDR_LOG3, 32'hffff_ffff);
        rd32(AERR_OFF_HDR_LOG3, h2[127:96]);
        drain("header log");
        // Check-disabled ECRC errors are dropped entirely
        pulse(32'h0008_0000, 32'h0000_0000, h, 1'b0, AERR_SEV_COR);
        rd32(AERR_OFF_UNC_STATUS, 32'h0000_0010);
        wr32(AERR_OFF_CAP_CTRL, 32'hffff_ffff);
        rd32(AERR_OFF_CAP_CTRL, 32'h0000_01e4);
        cmp32(32'h0000_0003, {30'h000_0000, gen, chk});
        pulse(32'h0008_0000, 32'h0000_0000, h, 1'b1, AERR_SEV_NONFATAL);
        rd32(AERR_OFF_UNC_STATUS, 32'h0008_0010);
        wr32(AERR_OFF_UNC_STATUS, 32'hffff_ffff);
        wr32(AERR_OFF_CAP_CTRL, 32'h0000_0000);
        drain("ecrc");
        // Random severity steers every uncorrectable type except ECRC
        sev_v = $urandom;
        wr32(AERR_OFF_UNC_SEV, sev_v);
        sev_v = sev_v & AERR_UNC_IMPL;
        rd32(AERR_OFF_UNC_SEV, sev_v);
        for (i = 0; i < 22; i++) if (AERR_UNC_IMPL[i] && i != AERR_UNC_ECRC_BIT) begin
            pulse(32'h0000_0001 << i, 32'h0000_0000, h, 1'b1,
                  sev_v[i] ? AERR_SEV_FATAL : AERR_SEV_NONFATAL);
            rd32(AERR_OFF_UNC_STATUS, 32'h0000_0001 << i);
            wr32(AERR_OFF_UNC_STATUS, 32'hffff_ffff);
        end
        drain("severity");
        wr32(AERR_OFF_COR_MASK, 32'h0000_0000);
        for (i = 0; i < 6; i++) begin
            pulse(32'h0000_0000, 32'h0000_0001 << cor_bits[i], h, 1'b1,
                  AERR_SEV_COR);
            rd32(AERR_OFF_COR_STATUS,
                 32'h0000_0001 << cor_bits[i]);
            wr32(AERR_OFF_COR_STATUS, 32'h0000_0001 << cor_bits[i]);
            rd32(AERR_OFF_COR_STATUS, 32'h0000_0000);
        end
        drain("correctable");
        wr32(AERR_OFF_COR_MASK, 32'hffff_ffff);
        rd32(AERR_OFF_COR_MASK, AERR_COR_IMPL);
        // Masked events carry a fresh header that must not reach the log
        for (i = 0; i < 6; i++) begin
            pulse(32'h0000_0000, 32'h0000_0001 << cor_bits[i], h2, 1'b0,
                  AERR_SEV_COR);
        end
        rd32(AERR_OFF_COR_STATUS, AERR_COR_IMPL);
        rd32(AERR_OFF_HDR_LOG0, h[31:0]);
        wr32(AERR_OFF_COR_STATUS, 32'hffff_ffff);
        wr32(AERR_OFF_COR_MASK, 32'h0000_0041);
        drain("masking");
        // Port reset spares sticky fields; power-on reset restores defaults
        @(posedge clk);
        port_rst <= 1'b1;
        repeat (2) @(posedge clk);
        port_rst <= 1'b0;
        rd32(AERR_OFF_UNC_SEV, sev_v);
        rd32(AERR_OFF_COR_MASK, 32'h0000_0041);
        // Let the last answer be compared before reset clears it
        repeat (2) @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd32(AERR_OFF_COR_MASK, AERR_COR_MASK_RST);
        pulse(32'h0000_0000, 32'h0000_2000, h2, 1'b0, AERR_SEV_COR);
        rd32(AERR_OFF_COR_STATUS, 32'h0000_2000);
        drain("resets");
        print_verdict();
    end
endmodule // aerr_regs_tb
